// ===== blrb_pkg.sv
package blrb_pkg;
   // target addresses per product option
   localparam logic [6:0] ADDR_HV_A = 7'h38;
   localparam logic [6:0] ADDR_HV_B = 7'h39;
   localparam logic [6:0] ADDR_LV = 7'h36;

   // writable register table: index, offset, power-on value
   localparam int NREG = 14;
   localparam int IX_GEN = 0;
   localparam int IX_AMB = 1;
   localparam int IX_RAMP = 2;
   localparam int IX_RES = 3;
   localparam int IX_BRT = 4;
   localparam int IX_ZB0 = 5;
   localparam int IX_ZT0 = 9;
   localparam int NBOUND = 4;
   localparam logic [7:0] REG_OFS [0:13] = '{
      8'h10, 8'h20, 8'h30, 8'h41, 8'ha0,
      8'h60, 8'h61, 8'h62, 8'h63,
      8'h70, 8'h71, 8'h72, 8'h73, 8'h74};
   localparam logic [7:0] REG_RST [0:13] = '{
      8'hb0, 8'h2c, 8'h00, 8'h00, 8'h7f,
      8'h33, 8'h66, 8'h99, 8'hcc,
      8'h19, 8'h33, 8'h4c, 8'h66, 8'h7f};

   // read-only zone information register
   localparam logic [7:0] OFS_ZINFO = 8'h40;
   localparam logic [7:0] RST_ZINFO = 8'h00;
   localparam int ZINFO_FLAG_BIT = 7;
   localparam logic [7:0] UNMAPPED_READ = 8'hff;

   // field positions
   localparam int GEN_ENABLE_BIT = 0;
   localparam int AMB_CTRL_BIT = 4;

   // link byte engine states
   typedef enum logic [2:0] {
      L_IDLE,
      L_ADDR,
      L_REG,
      L_WDATA,
      L_RDATA,
      L_SKIP
   } blrb_link_state_t;
endpackage

// ===== blrb_top.sv
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RL1: zone change pulls the open-drain interrupt low; otherwise it stays released.
// RL2: reading zone information over the link releases the interrupt.
// RL3: hardware enable low disables the link and returns all registers to reset.
// RL4: thermal shutdown only halts switching; registers are kept.
// RL5: START is SDA falling with SCL high; STOP is SDA rising with SCL high.
// RL6: only the controller makes START, STOP and repeated START.
// RL7: bus is busy from START until STOP, free after STOP.
// RL8: repeated START behaves like START and restarts address reception.
// RL9: SDA changes only while SCL is low, except START and STOP.
// RL10: target answers one fixed 7-bit address chosen per product option.
// RL11: first byte is address plus direction bit, 0 write, 1 read.
// RL12: in writes, second byte selects register, third byte is stored.
// RL13: bytes are eight bits, most significant bit first.
// RL14: controller gives the ninth clock and releases SDA during it.
// RL15: target pulls SDA low on the ninth clock after each received byte.
// RL16: 8-bit registers at listed offsets, each with its power-on value.
// RL17: bits without function read as one; only unmapped offsets do, zone information bits 6:3 read as zero.
// RL18: LED code comes from the zone target chosen by the zone boundaries.
// RL19: brightness register holds a 7-bit code, reset to full scale.
// RL20: zone information shows a change flag and the current zone.
// RL21: boundaries reset evenly spaced, targets reset rising to full scale.
// RL22: general configuration bit 0 enables the device.
// RL23: reads follow a register-address write and a repeated START.
// RL24: wrong address is not acknowledged; frame ignored until next START.
module blrb_top #(
   parameter logic [6:0] DEV_ADDR = blrb_pkg::ADDR_HV_A
) (
   input wire logic clk, // system clock
   input wire logic sys_rst, // synchronous reset
   input wire logic hw_enable_pin, // hardware enable pin
   input wire logic scl_in, // link clock
   input wire logic sda_in, // link data level
   output logic sda_out, // link data drive value
   output logic sda_oe, // link data pull enable
   input wire logic thermal_alarm, // die over temperature
   input wire logic [7:0] ambient_level, // averaged sensor level
   output logic zone_int_out, // interrupt drive value
   output logic zone_int_oe, // interrupt pull enable
   output logic [6:0] led_code, // brightness code to current sink
   output logic device_on, // device enabled
   output logic switching_en, // converter may switch
   output logic bus_busy // link between START and STOP
);

   // ---------------- link domain ----------------
   logic start_q;
   logic stop_q;
   logic frm_start_q;
   blrb_pkg::blrb_link_state_t state_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] ptr_q;
   logic ack_now_q;
   logic [7:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic wr_tgl_q;
   logic sda_oe_q;
   logic [7:0] tx_q;
   logic rd_tgl_q;
   logic [7:0] rd_word_q;

   // start seen: sda falls while scl high; cleared once taken
   wire start_clr = frm_start_q | ~hw_enable_pin;
   always_ff @(negedge sda_in or posedge start_clr) begin
      if (start_clr) begin
         start_q <= 1'b0;
      end else begin
         start_q <= scl_in; // RL5 RL6
      end
   end

   // stop seen: sda rises while scl high; start makes bus busy
   always_ff @(posedge sda_in or posedge start_q or negedge hw_enable_pin) begin
      if (!hw_enable_pin) begin
         stop_q <= 1'b1;
      end else if (start_q) begin
         stop_q <= 1'b0; // RL7
      end else begin
         stop_q <= scl_in; // RL5 RL7
      end
   end

   // byte assembly and decode
   wire [7:0] byte_in = {shift_q[6:0], sda_in}; // RL13
   wire addr_hit = (byte_in[7:1] == DEV_ADDR); // RL10
   wire byte_done = (cnt_q == 4'h7);

   // sampling edge: bits, state, pointer, write capture
   always_ff @(posedge scl_in or negedge hw_enable_pin) begin
      if (!hw_enable_pin) begin
         state_q <= blrb_pkg::L_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         ack_now_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         wr_tgl_q <= 1'b0;
      end else if (frm_start_q) begin
         state_q <= blrb_pkg::L_ADDR; // RL8
         cnt_q <= 4'h1;
         shift_q <= {7'h00, sda_in};
         ack_now_q <= 1'b0;
      end else if (cnt_q == 4'h8) begin
         cnt_q <= 4'h0;
         ack_now_q <= 1'b0;
         if (state_q == blrb_pkg::L_RDATA && sda_in) begin
            state_q <= blrb_pkg::L_SKIP; // RL14
         end
      end else begin
         shift_q <= byte_in;
         cnt_q <= cnt_q + 4'h1;
         if (byte_done) begin
            case (state_q)
               blrb_pkg::L_ADDR: begin
                  if (addr_hit) begin
                     ack_now_q <= 1'b1;
                     state_q <= byte_in[0] ? blrb_pkg::L_RDATA : blrb_pkg::L_REG; // RL11
                  end else begin
                     state_q <= blrb_pkg::L_SKIP; // RL24
                  end
               end
               blrb_pkg::L_REG: begin
                  ptr_q <= byte_in; // RL12 RL23
                  ack_now_q <= 1'b1;
                  state_q <= blrb_pkg::L_WDATA;
               end
               blrb_pkg::L_WDATA: begin
                  wr_addr_q <= ptr_q; // RL12
                  wr_data_q <= byte_in;
                  wr_tgl_q <= ~wr_tgl_q;
                  ack_now_q <= 1'b1;
               end
               default: begin
                  ack_now_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // driving edge: ack and read data change only with scl low
   always_ff @(negedge scl_in or negedge hw_enable_pin) begin
      if (!hw_enable_pin) begin
         frm_start_q <= 1'b0;
         sda_oe_q <= 1'b0;
         tx_q <= 8'h00;
         rd_tgl_q <= 1'b0;
      end else begin
         frm_start_q <= start_q;
         if (start_q) begin
            sda_oe_q <= 1'b0;
         end else if (cnt_q == 4'h8) begin
            sda_oe_q <= ack_now_q; // RL15 RL9
         end else if (state_q == blrb_pkg::L_RDATA && cnt_q == 4'h0) begin
            tx_q <= {rd_word_q[6:0], 1'b0}; // RL23
            sda_oe_q <= ~rd_word_q[7]; // RL13 RL9
            if (ptr_q == blrb_pkg::OFS_ZINFO) begin
               rd_tgl_q <= ~rd_tgl_q; // RL2
            end
         end else if (state_q == blrb_pkg::L_RDATA) begin
            sda_oe_q <= ~tx_q[7]; // RL9
            tx_q <= {tx_q[6:0], 1'b0};
         end else begin
            sda_oe_q <= 1'b0;
         end
      end
   end

   // ---------------- system domain ----------------
   logic hw_s1_q, hw_s2_q;
   logic th_s1_q, th_s2_q;
   logic wr_s1_q, wr_s2_q, wr_s3_q;
   logic rd_s1_q, rd_s2_q, rd_s3_q;
   logic busy_s1_q, busy_s2_q;
   logic low_q;

   // synchronisers for pin levels and link toggles
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hw_s1_q <= 1'b0;
         hw_s2_q <= 1'b0;
         th_s1_q <= 1'b0;
         th_s2_q <= 1'b0;
         wr_s1_q <= 1'b0;
         wr_s2_q <= 1'b0;
         wr_s3_q <= 1'b0;
         rd_s1_q <= 1'b0;
         rd_s2_q <= 1'b0;
         rd_s3_q <= 1'b0;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
      end else begin
         hw_s1_q <= hw_enable_pin;
         hw_s2_q <= hw_s1_q;
         th_s1_q <= thermal_alarm;
         th_s2_q <= th_s1_q;
         wr_s1_q <= wr_tgl_q;
         wr_s2_q <= wr_s1_q;
         wr_s3_q <= wr_s2_q;
         rd_s1_q <= rd_tgl_q;
         rd_s2_q <= rd_s1_q;
         rd_s3_q <= rd_s2_q;
         busy_s1_q <= ~stop_q;
         busy_s2_q <= busy_s1_q;
      end
   end

   // register reset also follows the hardware enable pin; thermal does not
   wire regs_rst = sys_rst | ~hw_s2_q; // RL3 RL4
   wire wr_pulse = wr_s2_q ^ wr_s3_q;
   wire rd_pulse = rd_s2_q ^ rd_s3_q;

   // writable register file, one flop word per entry
   logic [7:0] reg_q [0:blrb_pkg::NREG-1];
   wire [7:0] rd_chain [0:blrb_pkg::NREG];
   logic flag_q;
   logic [2:0] zone_q;
   wire [7:0] zinfo = {flag_q, 4'h0, zone_q}; // RL20

   // unmapped offsets read all ones
   assign rd_chain[0] = (ptr_q == blrb_pkg::OFS_ZINFO) ? zinfo : blrb_pkg::UNMAPPED_READ; // RL17
   for (genvar i = 0; i < blrb_pkg::NREG; i++) begin : g_reg
      wire hit_w = wr_pulse && (wr_addr_q == blrb_pkg::REG_OFS[i]);
      always_ff @(posedge clk) begin
         if (regs_rst) begin
            reg_q[i] <= blrb_pkg::REG_RST[i]; // RL16 RL19 RL21
         end else if (hit_w) begin
            reg_q[i] <= wr_data_q; // RL16
         end
      end
      assign rd_chain[i+1] = (ptr_q == blrb_pkg::REG_OFS[i]) ? reg_q[i] : rd_chain[i];
   end

   // zone from boundaries: count boundaries at or below the level up to the first one above it
   wire [blrb_pkg::NBOUND-1:0] above;
   for (genvar b = 0; b < blrb_pkg::NBOUND; b++) begin : g_bound
      assign above[b] = (ambient_level >= reg_q[blrb_pkg::IX_ZB0+b]);
   end
   wire [2:0] zone_nx = !above[0] ? 3'h0 :
                        !above[1] ? 3'h1 :
                        !above[2] ? 3'h2 :
                        !above[3] ? 3'h3 : 3'h4; // RL18
   wire zone_chg = (zone_nx != zone_q);
   wire [3:0] tgt_ix = 4'(blrb_pkg::IX_ZT0) + {1'b0, zone_q};
   wire [7:0] zone_tgt = reg_q[tgt_ix];
   wire amb_ctrl = reg_q[blrb_pkg::IX_AMB][blrb_pkg::AMB_CTRL_BIT];
   wire [6:0] code_nx = amb_ctrl ? zone_tgt[6:0] : reg_q[blrb_pkg::IX_BRT][6:0]; // RL18 RL19

   // zone tracking and change flag; a new change beats a clearing read
   always_ff @(posedge clk) begin
      if (regs_rst) begin
         zone_q <= 3'h0;
         flag_q <= 1'b0;
      end else begin
         zone_q <= zone_nx;
         if (zone_chg) begin
            flag_q <= 1'b1; // RL1
         end else if (rd_pulse) begin
            flag_q <= 1'b0; // RL2
         end
      end
   end

   // outputs and read word for the link
   always_ff @(posedge clk) begin
      if (regs_rst) begin
         led_code <= 7'h00;
         device_on <= 1'b0;
         switching_en <= 1'b0;
         rd_word_q <= 8'h00;
      end else begin
         led_code <= code_nx;
         device_on <= reg_q[blrb_pkg::IX_GEN][blrb_pkg::GEN_ENABLE_BIT]; // RL22
         switching_en <= reg_q[blrb_pkg::IX_GEN][blrb_pkg::GEN_ENABLE_BIT] & ~th_s2_q; // RL4
         rd_word_q <= rd_chain[blrb_pkg::NREG];
      end
   end

   // constant low drive value of both open-drain pins
   always_ff @(posedge clk) begin
      low_q <= 1'b0;
   end

   assign sda_out = low_q;
   assign sda_oe = sda_oe_q;
   assign zone_int_out = low_q;
   assign zone_int_oe = flag_q; // RL1
   assign bus_busy = busy_s2_q; // RL7

   // ---------------- checks ----------------
   // interrupt pin follows the change flag
   a_int_on_zone: assert property (@(posedge clk) disable iff (regs_rst) // RL1
      zone_chg |=> zone_int_oe) else $error("interrupt not pulled on zone change");

   a_int_level: assert property (@(posedge clk) disable iff (regs_rst) // RL1
      zone_int_oe |-> !zone_int_out) else $error("interrupt drive not low");

   a_int_read_clr: assert property (@(posedge clk) disable iff (regs_rst) // RL2
      (rd_pulse && !zone_chg) |=> !zone_int_oe) else $error("read did not release");

   // hardware enable low resets registers, thermal keeps them
   a_hw_reset_regs: assert property (@(posedge clk) // RL3
      (!hw_s2_q && !sys_rst)
      |=> (reg_q[blrb_pkg::IX_BRT] == blrb_pkg::REG_RST[blrb_pkg::IX_BRT] && !flag_q))
      else $error("hw enable low did not reset registers");

   a_hw_reset_on: assert property (@(posedge clk) // RL3
      (!hw_s2_q && !sys_rst) |=> !device_on) else $error("device on during hw reset");

   a_thermal_keep: assert property (@(posedge clk) disable iff (regs_rst) // RL4
      (th_s2_q && !wr_pulse) |=> $stable(reg_q[blrb_pkg::IX_GEN]) && !switching_en)
      else $error("thermal event touched registers");

   a_write_store: assert property (@(posedge clk) disable iff (regs_rst) // RL12
      (wr_pulse && wr_addr_q == blrb_pkg::REG_OFS[blrb_pkg::IX_BRT])
      |=> reg_q[blrb_pkg::IX_BRT] == $past(wr_data_q)) else $error("write not stored");

   // brightness source selection
   a_led_brt: assert property (@(posedge clk) disable iff (regs_rst) // RL19
      !amb_ctrl |=> led_code == $past(reg_q[blrb_pkg::IX_BRT][6:0]))
      else $error("led code not from brightness register");

   a_zone_code: assert property (@(posedge clk) disable iff (regs_rst) // RL18
      amb_ctrl ##1 amb_ctrl |-> led_code == $past(zone_tgt[6:0]))
      else $error("led code not from zone target");

   a_zinfo_flag: assert property (@(posedge clk) disable iff (regs_rst) // RL20
      zone_chg |=> (zinfo[blrb_pkg::ZINFO_FLAG_BIT] && zinfo[2:0] == $past(zone_nx)))
      else $error("zone information not updated");

   a_dev_enable: assert property (@(posedge clk) disable iff (regs_rst) // RL22
      ##1 device_on == $past(reg_q[blrb_pkg::IX_GEN][0])) else $error("enable bit ignored");

   // link-domain checks on byte handling
   a_ack_drive: assert property (@(negedge scl_in) disable iff (!hw_enable_pin) // RL15
      (cnt_q == 4'h8 && ack_now_q && !start_q) |=> sda_oe_q) else $error("no ack");

   a_idle_release: assert property (@(negedge scl_in) disable iff (!hw_enable_pin) // RL9
      (cnt_q == 4'h0 && state_q != blrb_pkg::L_RDATA) |=> !sda_oe_q)
      else $error("data pulled outside ack or read");

   a_addr_nack: assert property (@(posedge scl_in) disable iff (!hw_enable_pin) // RL24
      (!frm_start_q && state_q == blrb_pkg::L_ADDR && byte_done && !addr_hit)
      |=> (!ack_now_q && state_q == blrb_pkg::L_SKIP)) else $error("foreign address taken");

   a_addr_ack: assert property (@(posedge scl_in) disable iff (!hw_enable_pin) // RL10
      (!frm_start_q && state_q == blrb_pkg::L_ADDR && byte_done && addr_hit)
      |=> ack_now_q) else $error("own address not acked");

   a_dir_read: assert property (@(posedge scl_in) disable iff (!hw_enable_pin) // RL11
      (!frm_start_q && state_q == blrb_pkg::L_ADDR && byte_done && addr_hit && byte_in[0])
      |=> state_q == blrb_pkg::L_RDATA) else $error("read direction missed");

   a_restart_addr: assert property (@(posedge scl_in) disable iff (!hw_enable_pin) // RL8
      frm_start_q |=> (state_q == blrb_pkg::L_ADDR && cnt_q == 4'h1))
      else $error("start did not restart address");

   a_reg_ptr: assert property (@(posedge scl_in) disable iff (!hw_enable_pin) // RL12
      (!frm_start_q && state_q == blrb_pkg::L_REG && byte_done)
      |=> (ptr_q == $past(byte_in) && state_q == blrb_pkg::L_WDATA))
      else $error("register pointer not taken");

   a_wdata_tgl: assert property (@(posedge scl_in) disable iff (!hw_enable_pin) // RL12
      (!frm_start_q && state_q == blrb_pkg::L_WDATA && byte_done)
      |=> wr_tgl_q != $past(wr_tgl_q)) else $error("data byte not committed");

   a_read_nack: assert property (@(posedge scl_in) disable iff (!hw_enable_pin) // RL14
      (!frm_start_q && cnt_q == 4'h8 && state_q == blrb_pkg::L_RDATA && sda_in)
      |=> state_q == blrb_pkg::L_SKIP) else $error("nack did not end read");

endmodule

`default_nettype wire

// ===== blrb_host.sv
`timescale 1ns/100ps
`default_nettype none

// link controller model: directly driven clock and open-drain data, paced by clk
module blrb_host (
   input wire logic clk, // pacing clock
   input wire logic sda, // resolved data wire
   output logic scl, // link clock, idle high
   output logic sda_low // high pulls data low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // half bit time, five pacing cycles
   task automatic hp();
      repeat (5) @(negedge clk);
   endtask

   // start or repeated start, leaves clock low
   task automatic start();
      sda_low = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      sda_low = 1'b1;
      hp();
      scl = 1'b0;
      hp();
   endtask

   // stop from clock low, then bus idle
   task automatic stop();
      sda_low = 1'b1;
      hp();
      scl = 1'b1;
      hp();
      sda_low = 1'b0;
      hp();
   endtask

   // one byte out, msb first, then ack pulse
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = !b[i];
         hp();
         scl = 1'b1;
         hp();
         scl = 1'b0;
      end
      sda_low = 1'b0;
      hp();
      scl = 1'b1;
      hp();
      ack = !sda;
      scl = 1'b0;
   endtask

   // one byte in, msb first, then nack to end the read
   task automatic recv(output logic [7:0] b);
      sda_low = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         hp();
         scl = 1'b1;
         hp();
         b[i] = sda;
         scl = 1'b0;
      end
      hp();
      scl = 1'b1;
      hp();
      scl = 1'b0;
   endtask
endmodule

`default_nettype wire

// ===== tb.sv
`timescale 1ns/100ps
`default_nettype none

// compares one value and counts it
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
   $display("BAD %s exp %h got %h", nm, ex, got); end end

module tb;
   localparam logic [6:0] A = blrb_pkg::ADDR_HV_B;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic hw_enable_pin = 1'b1;
   logic thermal_alarm = 1'b0;
   logic [7:0] ambient_level = 8'h00;
   logic scl, sda_low, sda_out, sda_oe, zone_int_out, zone_int_oe;
   logic device_on, switching_en, bus_busy, ak;
   logic [6:0] led_code;
   logic [7:0] rv, lv;
   logic [2:0] zn;
   int errors = 0;
   int check_count = 0;
   // pull-up on the data wire
   wire logic sda = !(sda_low || (sda_oe && !sda_out));

   always #12.5 clk = ~clk;

   blrb_top #(.DEV_ADDR(A)) DUT (
      .clk(clk), .sys_rst(sys_rst), .hw_enable_pin(hw_enable_pin), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .thermal_alarm(thermal_alarm),
      .ambient_level(ambient_level), .zone_int_out(zone_int_out),
      .zone_int_oe(zone_int_oe), .led_code(led_code), .device_on(device_on),
      .switching_en(switching_en), .bus_busy(bus_busy));

   blrb_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // send a byte and expect the target ack
   task automatic tx(input logic [7:0] b);
      host.send(b, ak);
      `CHK("ack", 1'b1, ak)
   endtask

   // start, address write, register pointer
   task automatic hdr(input logic [7:0] ofs);
      host.start();
      `CHK("busy", 1'b1, bus_busy)
      tx({A, 1'b0});
      tx(ofs);
   endtask

   // register write, then let it land
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      hdr(ofs);
      tx(d);
      host.stop();
      `CHK("free", 1'b0, bus_busy)
      repeat (6) @(negedge clk);
   endtask

   // register read through repeated start
   task automatic rd(input logic [7:0] ofs);
      hdr(ofs);
      host.start();
      tx({A, 1'b1});
      host.recv(rv);
      host.stop();
   endtask

   // every writable register back at its power-on value
   task automatic chk_rst();
      for (int k = 0; k < blrb_pkg::NREG; k++) begin
         rd(blrb_pkg::REG_OFS[k]);
         `CHK("por", blrb_pkg::REG_RST[k], rv)
      end
      `CHK("led", blrb_pkg::REG_RST[blrb_pkg::IX_BRT][6:0], led_code)
      `CHK("on", 1'b0, device_on)
   endtask

   // bounded wait for a brightness code
   task automatic wait_led(input logic [6:0] ex);
      int i;
      for (i = 0; i < 100 && led_code !== ex; i++) @(negedge clk);
      `CHK("led", ex, led_code)
      if (led_code !== ex) wrap_up();
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      wrap_up();
   end

   initial begin
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      repeat (8) @(negedge clk);
      chk_rst();
      rd(blrb_pkg::OFS_ZINFO);
      `CHK("zinfo", blrb_pkg::RST_ZINFO, rv)
      rd(8'h50);
      `CHK("unmapped", blrb_pkg::UNMAPPED_READ, rv)
      $display("test reset values done");
      // inverted values everywhere, read-only place written too
      for (int k = 0; k < blrb_pkg::NREG; k++) wr(blrb_pkg::REG_OFS[k], ~blrb_pkg::REG_RST[k]);
      wr(blrb_pkg::OFS_ZINFO, 8'h55);
      for (int k = 0; k < blrb_pkg::NREG; k++) begin
         rd(blrb_pkg::REG_OFS[k]);
         `CHK("rw", ~blrb_pkg::REG_RST[k], rv)
      end
      rd(blrb_pkg::OFS_ZINFO);
      `CHK("ro", blrb_pkg::RST_ZINFO, rv)
      `CHK("on", 1'b1, device_on)
      $display("test write read done");
      // hardware enable pulse restores power-on values
      hw_enable_pin = 1'b0;
      repeat (10) @(negedge clk);
      hw_enable_pin = 1'b1;
      repeat (8) @(negedge clk);
      chk_rst();
      $display("test hardware enable done");
      // foreign address is ignored to the next start
      host.start();
      host.send({A ^ 7'h01, 1'b0}, ak);
      `CHK("nack", 1'b0, ak)
      host.send(8'h30, ak);
      host.send(8'h5a, ak);
      host.stop();
      rd(8'h30);
      `CHK("ignored", 8'h00, rv)
      $display("test address match done");
      // over temperature halts switching only
      wr(8'h10, 8'hb1);
      `CHK("sw", 1'b1, switching_en)
      thermal_alarm = 1'b1;
      repeat (10) @(negedge clk);
      `CHK("sw", 1'b0, switching_en)
      `CHK("on", 1'b1, device_on)
      rd(8'h10);
      `CHK("kept", 8'hb1, rv)
      thermal_alarm = 1'b0;
      $display("test thermal done");
      // ambient levels across every zone, each a zone change
      wr(8'h20, 8'h3c);
      for (int j = 0; j < 6; j++) begin
         lv = (j == 0) ? 8'h99 : (j == 1) ? 8'hff : (j == 2) ? 8'h32 :
              (j == 3) ? 8'h33 : (j == 4) ? 8'h66 : 8'hcb;
         zn = 3'h0;
         for (int k = 0; k < blrb_pkg::NBOUND; k++)
            if (blrb_pkg::REG_RST[blrb_pkg::IX_ZB0 + k] <= lv) zn++;
         ambient_level = lv;
         wait_led(blrb_pkg::REG_RST[blrb_pkg::IX_ZT0 + zn][6:0]);
         repeat (4) @(negedge clk);
         `CHK("int", 1'b1, zone_int_oe)
         `CHK("intlvl", 1'b0, zone_int_out)
         rd(blrb_pkg::OFS_ZINFO);
         `CHK("zinfo", {1'b1, 4'h0, zn}, rv)
         `CHK("int", 1'b0, zone_int_oe)
      end
      $display("test zones done");
      wrap_up();
   end
endmodule

`default_nettype wire
